// *** core/mcc_pkg.sv ***
//==============================================================================
//==============================================================================
package mcc_pkg;

    // =========================================================================
    // Register bus
    localparam int                  ADDR_W          = 8;
    localparam int                  DATA_W          = 8;
    localparam logic [ADDR_W-1:0]   OFS_MISC_CTRL   = 8'h20;
    localparam logic [ADDR_W-1:0]   OFS_CTRL_STAT   = 8'h29;
    localparam logic [ADDR_W-1:0]   OFS_IRQ_STAT    = 8'h2C;
    localparam logic [ADDR_W-1:0]   OFS_IRQ_MASK    = 8'h2D;

    // =========================================================================
    // Field positions and reset values
    localparam int                  MISC_SMS_BIT    = 0;
    localparam int                  MISC_CP_LSB     = 1;
    localparam int                  MISC_MCO_BIT    = 5;
    localparam logic [DATA_W-1:0]   MISC_RESET      = 8'h00;
    localparam int                  CS_FLAG_BIT     = 0;
    localparam int                  CS_IEN_BIT      = 1;
    localparam int                  CS_TB_LSB       = 2;
    localparam logic [1:0]          CS_TB_RESET     = 2'h0;
    localparam logic                CS_IEN_RESET    = 1'b0;
    localparam logic                CS_FLAG_RESET   = 1'b1;
    localparam int                  EVT_PERIOD_BIT  = 0;
    localparam int                  EVT_WAKE_BIT    = 1;
    localparam int                  EVT_N           = 2;
    localparam logic [EVT_N-1:0]    EVT_RESET       = 2'h0;

    // =========================================================================
    // Slow-mode divider codes and the width of the prescaler counter
    localparam logic [1:0]          CP_DIV4         = 2'h0;
    localparam logic [1:0]          CP_DIV8         = 2'h2;
    localparam logic [1:0]          CP_DIV16        = 2'h1;
    localparam logic [1:0]          CP_DIV32        = 2'h3;
    localparam int                  PRE_W           = 5;

    // =========================================================================
    // Time-base periods in oscillator cycles
    localparam int                  TB_CNT_W        = 19;
    localparam logic [TB_CNT_W-1:0] TB_CYC_0        = 19'h0_7D00;
    localparam logic [TB_CNT_W-1:0] TB_CYC_1        = 19'h0_FA00;
    localparam logic [TB_CNT_W-1:0] TB_CYC_2        = 19'h2_7100;
    localparam logic [TB_CNT_W-1:0] TB_CYC_3        = 19'h6_1A80;

    // Power state seen by the clock controller
    typedef enum logic [1:0] {
        MCC_PM_RUN,
        MCC_PM_ACTIVE_HALT,
        MCC_PM_HALT
    } mcc_pm_e;

endpackage

// *** core/mcc_tb_if.sv ***
//==============================================================================
// Link between the register side and the time-base counter
interface mcc_tb_if;
    import mcc_pkg::*;
    logic [1:0]          period_sel;
    logic                run;
    logic                elapsed;
    logic [TB_CNT_W-1:0] count;

    modport ctrl  (output period_sel, output run, input  elapsed, input  count);
    modport tbase (input  period_sel, input  run, output elapsed, output count);
endinterface

// *** core/mcc_clk_div.sv ***
//==============================================================================
// Prescaler: one free-running counter feeds every derived clock
module mcc_clk_div
    import mcc_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_slow,
    input  wire logic [1:0] i_div_sel,
    input  wire logic       i_stop,
    output logic            o_cpu_clk,
    output logic            o_half_clk
);
    logic [PRE_W-1:0] cnt_r;
    logic [PRE_W-1:0] cnt_nxt;
    logic [2:0]       bit_idx;

    // Counter bit n toggles at oscillator / 2^(n+1)
    assign cnt_nxt = cnt_r + 5'h1;
    assign bit_idx = !i_slow                ? 3'h0 :
                     (i_div_sel == CP_DIV4)  ? 3'h1 :
                     (i_div_sel == CP_DIV8)  ? 3'h2 :
                     (i_div_sel == CP_DIV16) ? 3'h3 : 3'h4;

    // Ratio changes switch taps at once, so one short phase may occur
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r      <= '0;
            o_cpu_clk  <= 1'b0;
            o_half_clk <= 1'b0;
        end else begin
            cnt_r      <= cnt_nxt;
            o_cpu_clk  <= i_stop ? 1'b0 : cnt_nxt[bit_idx];
            o_half_clk <= cnt_nxt[0];
        end
    end
endmodule // mcc_clk_div

// *** core/mcc_time_base.sv ***
//==============================================================================
// Time-base counter with period switch only at a period boundary
module mcc_time_base
    import mcc_pkg::*;
#(
    parameter logic [TB_CNT_W-1:0] P_CYC_0 = TB_CYC_0,
    parameter logic [TB_CNT_W-1:0] P_CYC_1 = TB_CYC_1,
    parameter logic [TB_CNT_W-1:0] P_CYC_2 = TB_CYC_2,
    parameter logic [TB_CNT_W-1:0] P_CYC_3 = TB_CYC_3
)(
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    mcc_tb_if.tbase   tb
);
    logic [1:0]          act_sel_r;
    logic [TB_CNT_W-1:0] cnt_r;
    logic [TB_CNT_W-1:0] limit;
    logic                wrap;

    // Active period decides the wrap point
    assign limit = (act_sel_r == 2'h0) ? P_CYC_0 :
                   (act_sel_r == 2'h1) ? P_CYC_1 :
                   (act_sel_r == 2'h2) ? P_CYC_2 : P_CYC_3;
    assign wrap  = tb.run && (cnt_r == limit - 19'h0_0001);
    assign tb.count = cnt_r;

    // Counter halts in full halt and resumes from where it stood
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_sel_r  <= CS_TB_RESET;
            cnt_r      <= '0;
            tb.elapsed <= 1'b0;
        end else begin
            tb.elapsed <= wrap;
            if (wrap) begin
                cnt_r     <= '0;
                act_sel_r <= tb.period_sel;
            end else if (tb.run) begin
                cnt_r <= cnt_r + 19'h0_0001;
            end
        end
    end
endmodule // mcc_time_base

// *** core/mcc_top.sv ***
//==============================================================================
// Main clock controller with time base
//
// Implementation choice: the plain strobed port.
module mcc_top
    import mcc_pkg::*;
#(
    parameter logic [TB_CNT_W-1:0] P_CYC_0 = TB_CYC_0,
    parameter logic [TB_CNT_W-1:0] P_CYC_1 = TB_CYC_1,
    parameter logic [TB_CNT_W-1:0] P_CYC_2 = TB_CYC_2,
    parameter logic [TB_CNT_W-1:0] P_CYC_3 = TB_CYC_3
)(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic              i_cpu_irq_mask,
    input  wire logic              i_halt_exec,
    input  wire logic              i_halt_wake,
    input  wire logic              i_wait_mode,
    output logic                   o_cpu_clk,
    output logic                   o_can_clk,
    output logic                   o_clk_out,
    output logic                   o_clk_out_en,
    output logic                   o_tb_irq_req,
    output logic                   o_wait_wake,
    output logic                   o_active_halt,
    output logic                   o_full_halt,
    output logic                   o_irq
);

    // =========================================================================
    // State
    mcc_pm_e           pm_r;
    mcc_pm_e           pm_nxt;
    logic [DATA_W-1:0] misc_r;
    logic [1:0]        tb_sel_r;
    logic              ien_r;
    logic              flag_r;
    logic              flag_nxt;
    logic [EVT_N-1:0]  evt_r;
    logic [EVT_N-1:0]  evt_nxt;
    logic [EVT_N-1:0]  mask_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              tb_req_r;
    logic              tb_req_nxt;
    logic              clk_out_r;
    logic              clk_out_en_r;
    logic              wait_wake_r;
    logic              irq_r;
    logic              active_halt_r;
    logic              full_halt_r;
    logic              half_clk;

    mcc_tb_if tb_link();

    // =========================================================================
    // Address decode
    wire               frozen     = (pm_r != MCC_PM_RUN);
    wire               hit_misc   = (i_addr == OFS_MISC_CTRL);
    wire               hit_cs     = (i_addr == OFS_CTRL_STAT);
    wire               hit_stat   = (i_addr == OFS_IRQ_STAT);
    wire               hit_mask   = (i_addr == OFS_IRQ_MASK);
    // Registers ignore writes while the core sleeps in either halt
    wire               wr_ok      = i_wr && !frozen;
    wire               wr_misc    = wr_ok && hit_misc;
    wire               wr_cs      = wr_ok && hit_cs;
    wire               wr_stat    = wr_ok && hit_stat;
    wire               wr_mask    = wr_ok && hit_mask;
    wire               rd_cs      = i_rd && hit_cs && !frozen;

    // =========================================================================
    // Field views
    wire               slow_clock_select   = misc_r[MISC_SMS_BIT];
    wire [1:0]         slow_divider_select = misc_r[MISC_CP_LSB +: 2];
    wire               clock_out_enable    = misc_r[MISC_MCO_BIT];
    wire               period_elapsed      = tb_link.elapsed;

    // Control/status image; upper nibble is hard zero
    wire [DATA_W-1:0]  cs_image = {4'h0, tb_sel_r, ien_r, flag_r};

    // =========================================================================
    // Power-state transitions
    // Wake from active-halt comes from the period event itself
    wire               tb_wake  = period_elapsed && ien_r;

    always_comb begin
        pm_nxt = pm_r;
        unique case (pm_r)
            MCC_PM_RUN: begin
                if (i_halt_exec) begin
                    pm_nxt = ien_r ? MCC_PM_ACTIVE_HALT : MCC_PM_HALT;
                end
            end
            MCC_PM_ACTIVE_HALT: begin
                if (tb_wake || i_halt_wake) begin
                    pm_nxt = MCC_PM_RUN;
                end
            end
            MCC_PM_HALT: begin
                // The time-base event cannot leave full halt
                if (i_halt_wake) begin
                    pm_nxt = MCC_PM_RUN;
                end
            end
        endcase
    end

    wire               halt_exit = frozen && (pm_nxt == MCC_PM_RUN);

    // =========================================================================
    // Flag: hardware set wins over the read that clears it
    always_comb begin
        flag_nxt = flag_r;
        if (rd_cs) begin
            flag_nxt = 1'b0;
        end
        if (period_elapsed) begin
            flag_nxt = 1'b1;
        end
    end

    // Sticky event bits, write one to clear, set beats clear
    always_comb begin
        evt_nxt = evt_r;
        if (wr_stat) begin
            evt_nxt = evt_r & ~i_wdata[EVT_N-1:0];
        end
        if (period_elapsed) begin
            evt_nxt[EVT_PERIOD_BIT] = 1'b1;
        end
        if (halt_exit) begin
            evt_nxt[EVT_WAKE_BIT] = 1'b1;
        end
    end

    // =========================================================================
    // Read mux; unmapped addresses answer zero
    always_comb begin
        rdata_nxt = '0;
        if (i_rd) begin
            if (hit_misc) begin
                rdata_nxt = misc_r;
            end else if (hit_cs) begin
                rdata_nxt = cs_image;
            end else if (hit_stat) begin
                rdata_nxt = {{(DATA_W-EVT_N){1'b0}}, evt_r};
            end else if (hit_mask) begin
                rdata_nxt = {{(DATA_W-EVT_N){1'b0}}, mask_r};
            end
        end
    end

    // Request follows flag and enable, gated by the CPU mask
    assign tb_req_nxt = flag_nxt && ien_r && !i_cpu_irq_mask;

    // =========================================================================
    // Register file
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            misc_r   <= MISC_RESET;
            tb_sel_r <= CS_TB_RESET;
            ien_r    <= CS_IEN_RESET;
            mask_r   <= EVT_RESET;
        end else begin
            if (wr_misc) begin
                misc_r <= i_wdata;
            end
            // Period written here only reaches the counter at its next wrap
            if (wr_cs) begin
                tb_sel_r <= i_wdata[CS_TB_LSB +: 2];
                ien_r    <= i_wdata[CS_IEN_BIT];
            end
            if (wr_mask) begin
                mask_r <= i_wdata[EVT_N-1:0];
            end
        end
    end

    // Flag, events and read data
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_r  <= CS_FLAG_RESET;
            evt_r   <= EVT_RESET;
            rdata_r <= '0;
        end else begin
            flag_r  <= flag_nxt;
            evt_r   <= evt_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // =========================================================================
    // Power state and status outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pm_r          <= MCC_PM_RUN;
            active_halt_r <= 1'b0;
            full_halt_r   <= 1'b0;
        end else begin
            pm_r          <= pm_nxt;
            active_halt_r <= (pm_nxt == MCC_PM_ACTIVE_HALT);
            full_halt_r   <= (pm_nxt == MCC_PM_HALT);
        end
    end

    // =========================================================================
    // Interrupt outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tb_req_r    <= 1'b0;
            wait_wake_r <= 1'b0;
            irq_r       <= 1'b0;
        end else begin
            tb_req_r    <= tb_req_nxt;
            // Wait leaves the block running; only the request ends it
            wait_wake_r <= i_wait_mode && tb_req_nxt && !tb_req_r;
            irq_r       <= |(evt_nxt & mask_r);
        end
    end

    // =========================================================================
    // Clock-out pin: held low in both halts to save power
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_out_r    <= 1'b0;
            clk_out_en_r <= 1'b0;
        end else begin
            clk_out_en_r <= clock_out_enable;
            clk_out_r    <= clock_out_enable && !frozen && half_clk;
        end
    end

    // =========================================================================
    // Sub-blocks, each free of the others' state
    assign tb_link.period_sel = tb_sel_r;
    assign tb_link.run        = (pm_r != MCC_PM_HALT);

    mcc_clk_div u_clk_div (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (i_rst_n),
        .i_slow     (slow_clock_select),
        .i_div_sel  (slow_divider_select),
        .i_stop     (frozen),
        .o_cpu_clk  (o_cpu_clk),
        .o_half_clk (half_clk)
    );

    mcc_time_base #(
        .P_CYC_0 (P_CYC_0),
        .P_CYC_1 (P_CYC_1),
        .P_CYC_2 (P_CYC_2),
        .P_CYC_3 (P_CYC_3)
    ) u_time_base (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .tb        (tb_link)
    );

    // =========================================================================
    // Output drive
    assign o_can_clk     = half_clk;
    assign o_rdata       = rdata_r;
    assign o_clk_out     = clk_out_r;
    assign o_clk_out_en  = clk_out_en_r;
    assign o_tb_irq_req  = tb_req_r;
    assign o_wait_wake   = wait_wake_r;
    assign o_active_halt = active_halt_r;
    assign o_full_halt   = full_halt_r;
    assign o_irq         = irq_r;

endmodule // mcc_top

// *** verification/mcc_checker.sv ***
//==============================================================================
// Port-level checks of the clock controller
module mcc_checker
    import mcc_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              i_cpu_irq_mask,
    input wire logic              i_halt_exec,
    input wire logic              i_halt_wake,
    input wire logic              i_wait_mode,
    input wire logic              o_cpu_clk,
    input wire logic              o_can_clk,
    input wire logic              o_clk_out,
    input wire logic              o_clk_out_en,
    input wire logic              o_tb_irq_req,
    input wire logic              o_wait_wake,
    input wire logic              o_active_halt,
    input wire logic              o_full_halt,
    input wire logic              o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // The past guard skips the first edge after reset, where the toggle has no history
    can_half_rate_a : assert property ($past(i_rst_n) |-> o_can_clk != $past(o_can_clk))
        else $error("can clock not toggling every cycle");
    csr_upper_zero_a : assert property ($past(i_rd) && $past(i_addr) == OFS_CTRL_STAT |-> o_rdata[7:4] == 4'h0)
        else $error("control status upper bits not zero");
    req_masked_a : assert property (o_tb_irq_req |-> !$past(i_cpu_irq_mask))
        else $error("time base request while cpu mask set");
    clkout_gate_a : assert property (o_clk_out |-> o_clk_out_en || $past(o_clk_out_en))
        else $error("clock out toggling while disabled");
    clkout_halt_a : assert property (o_active_halt && $past(o_active_halt) |-> !o_clk_out)
        else $error("clock out running in active halt");
    halt_entry_a : assert property (i_halt_exec && !o_active_halt && !o_full_halt |=> o_active_halt || o_full_halt)
        else $error("halt not entered");
    halt_hold_a : assert property (o_full_halt && !i_halt_wake |=> o_full_halt)
        else $error("full halt left without wake");
    halt_excl_a : assert property (!(o_active_halt && o_full_halt))
        else $error("both halt states at once");
    wait_wake_a : assert property (o_wait_wake |-> $past(i_wait_mode))
        else $error("wait wake outside wait");
endmodule // mcc_checker

bind mcc_top mcc_checker u_chk (.*);

// *** verification/mcc_cpu_model.sv ***
//==============================================================================
// Core side: halt and wake pulses, wait level dropped when the block wakes it
module mcc_cpu_model (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_halt_cmd,
    input  wire logic i_wake_cmd,
    input  wire logic i_wait_cmd,
    input  wire logic i_wait_wake,
    output logic      o_halt_exec,
    output logic      o_halt_wake,
    output logic      o_wait_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // Commands pass through one register stage; wait holds until the wake pulse
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_halt_exec <= 1'b0;
            o_halt_wake <= 1'b0;
            o_wait_mode <= 1'b0;
        end else begin
            o_halt_exec <= i_halt_cmd;
            o_halt_wake <= i_wake_cmd;
            if (i_wait_cmd) begin
                o_wait_mode <= 1'b1;
            end else if (i_wait_wake) begin
                o_wait_mode <= 1'b0;
            end
        end
    end
endmodule // mcc_cpu_model

// *** verification/test_mcc_top.sv ***
//==============================================================================
// Self-checking bench: registers, clocks, time base, power modes
module test_mcc_top;
    import mcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER [4] = '{8, 16, 40, 100};
    logic       clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, mask = 0;
    logic       h_cmd = 0, w_cmd = 0, wt_cmd = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, d, v;
    logic       cpu_clk, can_clk, clk_out, clk_out_en, req, wwake;
    logic       ahalt, fhalt, irq, hexec, hwake, wmode, b;
    logic [1:0] c, prev;
    int         err_count = 0, comparisons = 0, cyc = 0, t0, t1;

    mcc_top #(.P_CYC_0(TB_CNT_W'(PER[0])), .P_CYC_1(TB_CNT_W'(PER[1])),
              .P_CYC_2(TB_CNT_W'(PER[2])), .P_CYC_3(TB_CNT_W'(PER[3]))) u_dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_en), .i_rd(rd_en), .o_rdata(rdata), .i_cpu_irq_mask(mask),
        .i_halt_exec(hexec), .i_halt_wake(hwake), .i_wait_mode(wmode),
        .o_cpu_clk(cpu_clk), .o_can_clk(can_clk), .o_clk_out(clk_out),
        .o_clk_out_en(clk_out_en), .o_tb_irq_req(req), .o_wait_wake(wwake),
        .o_active_halt(ahalt), .o_full_halt(fhalt), .o_irq(irq));
    mcc_cpu_model u_cpu (.i_ref_clk(clk), .i_rst_n(rst_n), .i_halt_cmd(h_cmd),
        .i_wake_cmd(w_cmd), .i_wait_cmd(wt_cmd), .i_wait_wake(wwake),
        .o_halt_exec(hexec), .o_halt_wake(hwake), .o_wait_mode(wmode));

    initial begin
        forever #4 clk = ~clk;
    end
    // Cycle count for period measurement, and the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            test_done();
        end
    end

    // Expected CPU clock ratio from slow select and divider code
    function automatic int cpu_div(logic [7:0] m);
        return m[0] ? (4 << {m[1], m[2]}) : 2;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Whole-byte writes only; a read-modify-write would eat a pending flag
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 x = rdata;
    endtask
    task automatic wait_lv(ref logic s, input logic lv, input int n);
        for (int i = 0; i < n && s !== lv; i++) begin
            @(negedge clk);
        end
        chk({7'h0, s}, {7'h0, lv});
    endtask
    // A read that meets a period end leaves the flag set, so read once more
    task automatic clr_req;
        logic [7:0] x;
        bus_rd(OFS_CTRL_STAT, x);
        if (req !== 1'b0) bus_rd(OFS_CTRL_STAT, x);
    endtask
    task automatic wait_rise(output int t);
        logic p;
        if (req !== 1'b0) clr_req();
        p = req;
        t = 0;
        for (int i = 0; i < 400 && t == 0; i++) begin
            @(negedge clk);
            if (req === 1'b1 && p !== 1'b1) t = cyc;
            p = req;
        end
        if (t == 0) chk(8'h00, 8'h01);
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    //==========================================================================
    // Main sequence
    initial begin
        void'($urandom(15310));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus_rd(OFS_CTRL_STAT, d);
        chk(d, 8'h01);
        bus_rd(OFS_CTRL_STAT, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            bus_wr(OFS_MISC_CTRL, v);
            bus_rd(OFS_MISC_CTRL, d);
            chk(d, v);
        end
        bus_rd(8'h30 + 8'($urandom % 200), d);
        chk(d, 8'h00);
        // Every divider code, then normal mode, with clock-out running beside it
        for (int i = 0; i < 5; i++) begin
            v = (i < 4) ? 8'(8'h21 | (i << 1)) : 8'h20;
            bus_wr(OFS_MISC_CTRL, v);
            // The old tap still shows for one edge; measure only the new one
            repeat (2) @(negedge clk);
            wait_lv(cpu_clk, 1'b0, 40);
            wait_lv(cpu_clk, 1'b1, 40);
            t0 = cyc;
            wait_lv(cpu_clk, 1'b0, 40);
            wait_lv(cpu_clk, 1'b1, 40);
            chk(8'(cyc - t0), 8'(cpu_div(v)));
            b = clk_out;
            @(negedge clk);
            chk({6'h0, clk_out_en, clk_out ^ b}, 8'h03);
        end
        // Period switch lands only at the end of the running period
        bus_wr(OFS_CTRL_STAT, 8'h02);
        bus_rd(OFS_CTRL_STAT, d);
        wait_rise(t0);
        prev = 2'h0;
        for (int k = 1; k < 5; k++) begin
            c = 2'(k);
            bus_wr(OFS_CTRL_STAT, {4'h0, c, 2'b10});
            bus_rd(OFS_CTRL_STAT, d);
            chk({7'h0, req}, 8'h00);
            wait_rise(t1);
            chk(8'(t1 - t0), 8'(PER[prev]));
            bus_rd(OFS_CTRL_STAT, d);
            wait_rise(t0);
            chk(8'(t0 - t1), 8'(PER[c]));
            prev = c;
        end
        // CPU mask holds the request back but not the flag
        @(posedge clk);
        mask <= 1'b1;
        bus_rd(OFS_CTRL_STAT, d);
        repeat (12) @(negedge clk);
        chk({7'h0, req}, 8'h00);
        bus_rd(OFS_CTRL_STAT, d);
        chk(d, 8'h03);
        @(posedge clk);
        mask <= 1'b0;
        // Event status, mask and write-one-to-clear
        bus_wr(OFS_IRQ_MASK, 8'h01);
        wait_lv(irq, 1'b1, 20);
        bus_wr(OFS_IRQ_MASK, 8'h00);
        repeat (2) @(negedge clk);
        chk({7'h0, irq}, 8'h00);
        wait_rise(t0);
        bus_wr(OFS_IRQ_STAT, 8'h01);
        bus_rd(OFS_IRQ_STAT, d);
        chk(d, 8'h00);
        // Active halt: writes frozen, period end wakes the core
        bus_wr(OFS_CTRL_STAT, 8'h0E);
        h_cmd <= 1'b1;
        @(posedge clk);
        h_cmd <= 1'b0;
        wait_lv(ahalt, 1'b1, 5);
        bus_wr(OFS_MISC_CTRL, 8'h00);
        wait_lv(ahalt, 1'b0, 120);
        bus_rd(OFS_MISC_CTRL, d);
        chk(d, 8'h20);
        // Full halt: only the outside wake ends it
        bus_wr(OFS_CTRL_STAT, 8'h0C);
        h_cmd <= 1'b1;
        @(posedge clk);
        h_cmd <= 1'b0;
        wait_lv(fhalt, 1'b1, 5);
        repeat (250) @(negedge clk);
        chk({7'h0, fhalt}, 8'h01);
        @(posedge clk);
        w_cmd <= 1'b1;
        @(posedge clk);
        w_cmd <= 1'b0;
        wait_lv(fhalt, 1'b0, 5);
        // Wait mode ends on the next time-base request
        bus_wr(OFS_CTRL_STAT, 8'h02);
        wt_cmd <= 1'b1;
        @(posedge clk);
        wt_cmd <= 1'b0;
        wait_lv(wmode, 1'b1, 4);
        // Only a rising request wakes, so drop a request left standing
        clr_req();
        wait_lv(wmode, 1'b0, 120);
        test_done();
    end
endmodule // test_mcc_top
